// file: dv/toc_cpu_model.sv
// Bus master model of the CPU side of the output compare block
`timescale 1ns/100ps
module toc_cpu_model (
  input wire logic core_clk,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rdData;
  logic rdErr;
  // Starts one edge late so a release is never overwritten in the same step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr16(input logic [7:0] hiAddr, input logic [15:0] v);
    xfer(1'b1, hiAddr, {24'h0, v[15:8]});
    xfer(1'b1, hiAddr + 8'h04, {24'h0, v[7:0]});
  endtask
endmodule // toc_cpu_model

// file: dv/toc_output_compare_properties.sv
// Port-level assertions for the timer output compare block
`timescale 1ns/100ps
module toc_output_compare_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timerTick,
  input wire logic [1:0] irqServiced,
  input wire logic [1:0] pinDirectionBit,
  input wire logic [1:0] portData,
  input wire logic [1:0] irqRequest,
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOutEnableN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the channel A action so the port override can be judged
  logic [1:0] actA_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      actA_q <= 2'h0;
    end else if (pready && pwrite && paddr == toc_pkg::OFS_CTRL) begin
      actA_q <= pwdata[toc_pkg::CTRL_ACTA_LSB +: 2];
    end
  end
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("late pready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("bus outputs not idle");
  property p_decode;
    pready |-> pslverr == (paddr > toc_pkg::OFS_CAPTURE || paddr[1:0] != 2'h0);
  endproperty
  a_decode: assert property (p_decode) else $error("bad error decode");
  property p_oen; 1'b1 |=> pinOutEnableN == ~$past(pinDirectionBit); endproperty
  a_oen: assert property (p_oen) else $error("pin enable wrong");
  property p_irq_clear;
    irqServiced[0] && !timerTick |-> ##2 !irqRequest[0];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq kept");
  property p_irq_cause;
    $rose(irqRequest[0]) |-> $past(timerTick, 2) || $past(pready && pwrite, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
  property p_port;
    actA_q == toc_pkg::ACT_NONE |=> pinOut[0] == $past(portData[0]);
  endproperty
  a_port: assert property (p_port) else $error("port value lost");
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irqRequest[0]));
  c_wave: cover property (actA_q != 2'h0 && pinOut[0]);
endmodule // toc_output_compare_properties
bind toc_output_compare toc_output_compare_properties u_props (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timerTick(timerTick),
  .irqServiced(irqServiced), .pinDirectionBit(pinDirectionBit),
  .portData(portData), .irqRequest(irqRequest), .pinOut(pinOut),
  .pinOutEnableN(pinOutEnableN));

// file: dv/toc_output_compare_tb.sv
// Self-checking bench for the timer output compare block
`timescale 1ns/100ps
module toc_output_compare_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic timerTick = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ch;
  logic [7:0] paddr, hi;
  logic [31:0] pwdata, prdata;
  logic [1:0] irqServiced = 2'h0, pinDirectionBit = 2'h0, portData = 2'h0;
  logic [1:0] irqRequest, pinOut, pinOutEnableN, act, wexp = 2'h0;
  logic [15:0] c;
  int n_errors = 0, checks = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  toc_output_compare dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerTick(timerTick), .irqServiced(irqServiced),
    .pinDirectionBit(pinDirectionBit), .portData(portData),
    .irqRequest(irqRequest), .pinOut(pinOut), .pinOutEnableN(pinOutEnableN));
  toc_cpu_model cpu (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task automatic conclude();
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    cpu.xfer(1'b0, a, 32'h0);
    chk(cpu.rdData, exp);
  endtask
  task automatic tick();
    @(posedge core_clk);
    timerTick <= 1'b1;
    @(posedge core_clk);
    timerTick <= 1'b0;
  endtask
  function automatic logic nextWave(input logic [1:0] a, input logic w);
    case (a)
      toc_pkg::ACT_TOGGLE: return ~w;
      toc_pkg::ACT_CLEAR: return 1'b0;
      toc_pkg::ACT_SET: return 1'b1;
      default: return w;
    endcase
  endfunction
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(56558));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(toc_pkg::OFS_WAVE, 32'h0);
    cpu.xfer(1'b0, 8'h28, 32'h0);
    chk({31'h0, cpu.rdErr}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      ch = i[0];
      act = i[2:1];
      c = 16'($urandom());
      portData <= 2'($urandom());
      hi = ch ? toc_pkg::OFS_CMPB_HI : toc_pkg::OFS_CMPA_HI;
      cpu.xfer(1'b1, toc_pkg::OFS_CTRL,
               {22'h0, 2'h3, ch ? {act, 2'h0} : {2'h0, act}, 4'h0});
      cpu.wr16(hi, c);
      rdChk(hi, {24'h0, c[15:8]});
      cpu.xfer(1'b1, toc_pkg::OFS_COUNT, {16'h0, c});
      tick();
      cpu.xfer(1'b0, toc_pkg::OFS_FLAGS, 32'h0);
      chk({31'h0, cpu.rdData[ch]}, 32'h0);
      cpu.xfer(1'b1, toc_pkg::OFS_COUNT, {16'h0, c - 16'h1});
      tick();
      tick();
      wexp[ch] = nextWave(act, wexp[ch]);
      cpu.xfer(1'b0, toc_pkg::OFS_FLAGS, 32'h0);
      chk({31'h0, cpu.rdData[ch]}, 32'h1);
      rdChk(toc_pkg::OFS_WAVE, {30'h0, wexp});
      chk({31'h0, irqRequest[ch]}, 32'h1);
      chk({31'h0, pinOut[ch]}, {31'h0, act != 0 ? wexp[ch] : portData[ch]});
      if (act == toc_pkg::ACT_SET) begin
        irqServiced <= 2'h1 << ch;
        @(posedge core_clk);
        irqServiced <= 2'h0;
      end else begin
        cpu.xfer(1'b1, toc_pkg::OFS_FLAGS, {30'h0, 2'h1 << ch});
      end
      cpu.xfer(1'b1, toc_pkg::OFS_FORCE, {30'h0, 2'h1 << ch});
      wexp[ch] = nextWave(act, wexp[ch]);
      rdChk(toc_pkg::OFS_WAVE, {30'h0, wexp});
      cpu.xfer(1'b0, toc_pkg::OFS_FLAGS, 32'h0);
      chk({31'h0, cpu.rdData[ch]}, 32'h0);
    end
    pinDirectionBit <= 2'h3;
    repeat (2) @(posedge core_clk);
    chk({30'h0, pinOutEnableN}, 32'h0);
    cpu.xfer(1'b1, toc_pkg::OFS_CTRL, {28'h0, toc_pkg::MODE_FAST8});
    rdChk(toc_pkg::OFS_WAVE, {30'h0, wexp});
    cpu.wr16(toc_pkg::OFS_CMPB_HI, 16'h0010);
    rdChk(toc_pkg::OFS_CMPB_LO, 32'h10);
    cpu.xfer(1'b1, toc_pkg::OFS_COUNT, 32'hf);
    repeat (2) tick();
    cpu.xfer(1'b0, toc_pkg::OFS_FLAGS, 32'h0);
    chk({31'h0, cpu.rdData[1]}, 32'h0);
    cpu.xfer(1'b1, toc_pkg::OFS_COUNT, 32'hfe);
    repeat (19) tick();
    cpu.xfer(1'b0, toc_pkg::OFS_FLAGS, 32'h0);
    chk({31'h0, cpu.rdData[1]}, 32'h1);
    cpu.xfer(1'b1, toc_pkg::OFS_FORCE, 32'h3);
    rdChk(toc_pkg::OFS_WAVE, {30'h0, wexp});
    conclude();
  end
endmodule // toc_output_compare_tb

// file: hdl/toc_output_compare.sv
// Two-channel output compare unit of a 16-bit timer with APB registers
//
// Notes on behaviour
// - Each channel compares all 16 counter bits with its compare value always.
// - Match flag sets one timer tick after equality, not immediately.
// - Enabled flag requests interrupt; servicing the interrupt clears the flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - In selected modes channel A compare value sets counter ceiling.
// - Compare value double buffered in pulse width modes only.
// - Buffered value moves to active compare only at ceiling or 0xFFFF.
// - CPU accesses buffer when double buffered, else active compare value.
// - Compare high byte is read directly, never through the shared latch.
// - High byte write loads latch; low write stores both bytes together.
// - Force strobe in non-pulse-width modes applies action without flag.
// - Counter write suppresses all matches in the following timer tick.
// - Counter written equal to variable ceiling counts on to 0xFFFF.
// - Waveform output register keeps its value across mode changes.
// - Output action is not buffered; takes effect at next match.
// - Reset clears each waveform output register to zero.
// - Nonzero action overrides port value; direction still from direction bit.
// - Action zero leaves the waveform output register unchanged on match.
// - Output action has no influence on input capture.
// - Mode 0 is normal, modes 4 and 12 are clear on match.
// - CPU counter write wins over clear or count in same cycle.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module toc_output_compare (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timerTick,
  input wire logic [1:0] irqServiced,
  input wire logic [1:0] pinDirectionBit,
  input wire logic [1:0] portData,
  output logic [1:0] irqRequest,
  output logic [1:0] pinOut,
  output logic [1:0] pinOutEnableN
);

  function automatic logic isPulseMode(input logic [3:0] mode);
    isPulseMode = !(mode == toc_pkg::MODE_NORMAL ||
                    mode == toc_pkg::MODE_CLR_CMPA ||
                    mode == toc_pkg::MODE_CLR_CAP ||
                    mode == toc_pkg::MODE_RESERVED);
  endfunction

  // Register select, shared by every write strobe of the bus decode
  function automatic logic regHit(input logic [7:0] addr,
                                  input logic [7:0] ofs);
    regHit = addr == ofs;
  endfunction

  function automatic logic [1:0] applyAction(input logic [1:0] act,
                                             input logic cur);
    case (act)
      toc_pkg::ACT_TOGGLE: applyAction = {1'b1, ~cur};
      toc_pkg::ACT_CLEAR: applyAction = 2'b10;
      toc_pkg::ACT_SET: applyAction = 2'b11;
      default: applyAction = {1'b0, cur};
    endcase
  endfunction

  logic [9:0] ctrl_q;
  logic [15:0] count_q;
  logic [15:0] capture_q;
  logic [7:0] hiLatch_q;
  logic [15:0] cmpActive_q [2];
  logic [15:0] cmpBuffer_q [2];
  logic [1:0] matchFlag_q;
  logic [1:0] wave_q;
  logic blockNext_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [1:0] irqRequest_q;
  logic [1:0] pinOut_q;
  logic [1:0] pinOutEnableN_q;

  logic [3:0] mode;
  logic [1:0] action [2];
  logic [1:0] irqEnable;
  logic pulseMode;
  logic [15:0] ceiling;
  logic atCeiling;
  logic wrapNow;
  logic [1:0] match;
  logic [1:0] matchHit;
  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic addrMapped;
  logic counterWrite;
  logic [1:0] forceStrobe;
  logic [1:0] cmpHiWrite;
  logic [1:0] cmpLoWrite;
  logic [31:0] readData;
  logic ctrlWrite;
  logic flagsWrite;
  logic captureWrite;
  logic [1:0] waveUpdate;
  logic [1:0] waveNext [2];

  assign mode = ctrl_q[toc_pkg::CTRL_MODE_LSB +: 4];
  assign action[0] = ctrl_q[toc_pkg::CTRL_ACTA_LSB +: 2];
  assign action[1] = ctrl_q[toc_pkg::CTRL_ACTB_LSB +: 2];
  assign irqEnable = ctrl_q[toc_pkg::CTRL_IRQEN_LSB +: 2];
  assign pulseMode = isPulseMode(mode);

  // The access phase is taken on the second access cycle so that
  // read data and pready both come from flip-flops.
  assign apbAccess = psel && penable && pready_q;
  assign apbWrite = apbAccess && pwrite;
  assign apbRead = apbAccess && !pwrite;
  assign ctrlWrite = apbWrite && regHit(paddr, toc_pkg::OFS_CTRL);
  assign flagsWrite = apbWrite && regHit(paddr, toc_pkg::OFS_FLAGS);
  assign captureWrite = apbWrite && regHit(paddr, toc_pkg::OFS_CAPTURE);
  assign counterWrite = apbWrite && regHit(paddr, toc_pkg::OFS_COUNT);
  // Strobes are dropped in pulse width modes, where a forced edge
  // would break the period the waveform is built on.
  assign forceStrobe = (apbWrite && regHit(paddr, toc_pkg::OFS_FORCE) &&
                        !pulseMode) ? pwdata[1:0] : 2'b00;
  assign cmpHiWrite[0] = apbWrite && regHit(paddr, toc_pkg::OFS_CMPA_HI);
  assign cmpHiWrite[1] = apbWrite && regHit(paddr, toc_pkg::OFS_CMPB_HI);
  assign cmpLoWrite[0] = apbWrite && regHit(paddr, toc_pkg::OFS_CMPA_LO);
  assign cmpLoWrite[1] = apbWrite && regHit(paddr, toc_pkg::OFS_CMPB_LO);

  always_comb begin
    case (mode)
      toc_pkg::MODE_CLR_CMPA, toc_pkg::MODE_FAST_CMPA: begin
        ceiling = cmpActive_q[0];
      end
      toc_pkg::MODE_CLR_CAP, toc_pkg::MODE_FAST_CAP: begin
        ceiling = capture_q;
      end
      toc_pkg::MODE_FAST8: begin
        ceiling = toc_pkg::CEIL_8BIT;
      end
      toc_pkg::MODE_FAST9: begin
        ceiling = toc_pkg::CEIL_9BIT;
      end
      toc_pkg::MODE_FAST10: begin
        ceiling = toc_pkg::CEIL_10BIT;
      end
      default: begin
        ceiling = toc_pkg::CEIL_MAX;
      end
    endcase
  end

  // A blocked tick also ignores the ceiling, so a counter written equal
  // to the ceiling runs on to the top of the range and wraps there.
  assign atCeiling = count_q == ceiling && !blockNext_q;
  assign wrapNow = timerTick &&
                   (atCeiling || count_q == toc_pkg::CEIL_MAX);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gCmp
      assign match[ch] = count_q == cmpActive_q[ch];
      assign matchHit[ch] = timerTick && match[ch] && !blockNext_q;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= toc_pkg::CTRL_RESET;
    end else if (ctrlWrite) begin
      ctrl_q <= pwdata[9:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_q <= toc_pkg::CMP_RESET;
    end else if (captureWrite) begin
      capture_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= toc_pkg::COUNT_RESET;
    end else if (counterWrite) begin
      count_q <= pwdata[15:0];
    end else if (wrapNow) begin
      count_q <= toc_pkg::COUNT_RESET;
    end else if (timerTick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Blocking lasts until the next timer tick, even if the timer is
  // stopped for a long time after the write.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blockNext_q <= 1'b0;
    end else if (counterWrite) begin
      blockNext_q <= 1'b1;
    end else if (timerTick) begin
      blockNext_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hiLatch_q <= 8'h00;
    end else if (|cmpHiWrite) begin
      hiLatch_q <= pwdata[7:0];
    end
  end

  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cmpBuffer_q[ch] <= toc_pkg::CMP_RESET;
        end else if (cmpLoWrite[ch] && pulseMode) begin
          cmpBuffer_q[ch] <= {hiLatch_q, pwdata[7:0]};
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cmpActive_q[ch] <= toc_pkg::CMP_RESET;
        end else if (cmpLoWrite[ch] && !pulseMode) begin
          cmpActive_q[ch] <= {hiLatch_q, pwdata[7:0]};
        end else if (pulseMode && wrapNow) begin
          cmpActive_q[ch] <= cmpBuffer_q[ch];
        end
      end

      // A new match sets the flag even if software clears it in the
      // same cycle, so no event is lost.
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          matchFlag_q[ch] <= 1'b0;
        end else if (matchHit[ch]) begin
          matchFlag_q[ch] <= 1'b1;
        end else if (flagsWrite && pwdata[ch]) begin
          matchFlag_q[ch] <= 1'b0;
        end else if (irqServiced[ch] && irqEnable[ch]) begin
          matchFlag_q[ch] <= 1'b0;
        end
      end

      // Next output state from the action; the high bit marks a change
      always_comb begin
        waveNext[ch] = applyAction(action[ch], wave_q[ch]);
      end

      // Forcing uses the same path as a real match, minus the flag.
      assign waveUpdate[ch] = matchHit[ch] || forceStrobe[ch];

      // Mode changes never touch this register.
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          wave_q[ch] <= toc_pkg::WAVE_RESET[ch];
        end else if (waveUpdate[ch]) begin
          wave_q[ch] <= waveNext[ch][0];
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          irqRequest_q[ch] <= 1'b0;
        end else begin
          irqRequest_q[ch] <= matchFlag_q[ch] && irqEnable[ch];
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          pinOut_q[ch] <= 1'b0;
          pinOutEnableN_q[ch] <= 1'b1;
        end else begin
          pinOut_q[ch] <= (action[ch] != toc_pkg::ACT_NONE) ?
                          wave_q[ch] : portData[ch];
          pinOutEnableN_q[ch] <= !pinDirectionBit[ch];
        end
      end
    end
  endgenerate

  always_comb begin
    readData = 32'h0000_0000;
    addrMapped = 1'b1;
    case (paddr)
      toc_pkg::OFS_CTRL: begin
        readData[9:0] = ctrl_q;
      end
      toc_pkg::OFS_FLAGS: begin
        readData[1:0] = matchFlag_q;
      end
      toc_pkg::OFS_FORCE: begin
        readData = 32'h0000_0000;
      end
      toc_pkg::OFS_COUNT: begin
        readData[15:0] = count_q;
      end
      toc_pkg::OFS_CMPA_HI: begin
        readData[7:0] = pulseMode ?
          cmpBuffer_q[0][15:8] : cmpActive_q[0][15:8];
      end
      toc_pkg::OFS_CMPA_LO: begin
        readData[7:0] = pulseMode ?
          cmpBuffer_q[0][7:0] : cmpActive_q[0][7:0];
      end
      toc_pkg::OFS_CMPB_HI: begin
        readData[7:0] = pulseMode ?
          cmpBuffer_q[1][15:8] : cmpActive_q[1][15:8];
      end
      toc_pkg::OFS_CMPB_LO: begin
        readData[7:0] = pulseMode ?
          cmpBuffer_q[1][7:0] : cmpActive_q[1][7:0];
      end
      toc_pkg::OFS_WAVE: begin
        readData[1:0] = wave_q;
      end
      toc_pkg::OFS_CAPTURE: begin
        readData[15:0] = capture_q;
      end
      default: begin
        addrMapped = 1'b0;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  // The extra cycle buys registered read data at the cost of bus speed.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
    end
  end

  // Read data stands only while pready is high and is zero otherwise.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && penable && !pready_q && !pwrite) begin
      prdata_q <= readData;
    end else begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // An unmapped address is flagged with the ready pulse, write ignored.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= psel && penable && !pready_q && !addrMapped;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irqRequest = irqRequest_q;
  assign pinOut = pinOut_q;
  assign pinOutEnableN = pinOutEnableN_q;

endmodule // toc_output_compare

// file: include/toc_pkg.sv
// Constants for the 16-bit timer output compare block
package toc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_FORCE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_CMPA_HI = 8'h10;
  localparam logic [7:0] OFS_CMPA_LO = 8'h14;
  localparam logic [7:0] OFS_CMPB_HI = 8'h18;
  localparam logic [7:0] OFS_CMPB_LO = 8'h1c;
  localparam logic [7:0] OFS_WAVE = 8'h20;
  localparam logic [7:0] OFS_CAPTURE = 8'h24;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_IRQEN_LSB = 8;
  // Mode encodings
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLR_CMPA = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_CLR_CAP = 4'hc;
  localparam logic [3:0] MODE_RESERVED = 4'hd;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hf;
  // Fixed ceilings and limits
  localparam logic [15:0] CEIL_8BIT = 16'h00ff;
  localparam logic [15:0] CEIL_9BIT = 16'h01ff;
  localparam logic [15:0] CEIL_10BIT = 16'h03ff;
  localparam logic [15:0] CEIL_MAX = 16'hffff;
  // Output action encodings
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // Reset values
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] WAVE_RESET = 2'h0;
endpackage
